// >>> fault_eval.sv
// Shutdown and load-dump fault evaluator with register port and interrupt.
// Assumes inputs synchronous to core_clk; measurements already scaled.
`timescale 1ns/1ps
module fault_eval
  import fault_pkg::*;
#(
  parameter int TICK = TICK_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata_q,
  input  wire meas_t       meas,
  input  wire cb_t         cb,
  input  wire logic        engine_running,
  input  wire logic        ecu_msg,
  input  wire logic        ecu_check_en,
  input  wire logic        phase_rev,
  input  wire logic [2:0]  svc_expired,
  input  wire logic        remote_lock,
  input  wire logic        topo_known,
  input  wire logic        mode_cmd,
  input  wire logic        dis_prot,
  input  wire logic        btn_mute,
  input  wire logic        btn_lamp,
  output alarm_t           sd_q,
  output alarm_t           ld_q,
  output alarm_t           warn_q,
  output logic             svc_reset_q,
  output logic             done_msg_q,
  output logic             irq_q
);

  function automatic logic [17:0] x3(input logic [15:0] v);
    x3 = {1'b0, v, 1'b0} + {2'b00, v};
  endfunction

  // Compare 3*x against the sum, avoiding a divider
  function automatic logic unb_over(input logic [15:0] a, b, c, lim);
    logic [17:0] s;
    logic [17:0] dv;
    logic [17:0] p [3];
    unb_over = 1'b0;
    s = {2'b00, a} + {2'b00, b} + {2'b00, c};
    p[0] = x3(a);
    p[1] = x3(b);
    p[2] = x3(c);
    for (int k = 0; k < 3; k++) begin
      dv = (p[k] > s) ? p[k] - s : s - p[k];
      if (dv > x3(lim)) begin
        unb_over = 1'b1;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Register file
  logic [1:0]  cfg_q;
  alarm_t      latch_q, class_q, sts_q, mask_q, act_q;
  logic [15:0] prm_q [NP];
  logic [7:0]  poff;
  logic [3:0]  pidx;
  logic        pvalid;

  assign poff   = addr - R_PRM0;
  assign pidx   = poff[5:2];
  // High offset bits checked too, so far addresses never alias a parameter
  assign pvalid = addr >= R_PRM0 && poff[1:0] == 2'b00 && poff[7:6] == 2'b00 && pidx < 4'(NP);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_q   <= '0;
      latch_q <= '0;
      class_q <= CLASS_RST;
      mask_q  <= '0;
      for (int k = 0; k < NP; k++) begin
        prm_q[k] <= PRM_RST;
      end
    end else if (wr) begin
      unique case (addr)
        R_CFG:   cfg_q   <= wdata[1:0];
        R_LATCH: latch_q <= wdata[NA-1:0];
        R_CLASS: class_q <= wdata[NA-1:0];
        R_MASK:  mask_q  <= wdata[NA-1:0];
        default: begin
          if (pvalid) begin
            prm_q[pidx] <= wdata[15:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (rd) begin
      unique case (addr)
        R_CFG:   rdata_q <= 32'(cfg_q);
        R_LATCH: rdata_q <= 32'(latch_q);
        R_CLASS: rdata_q <= 32'(class_q);
        R_STAT:  rdata_q <= 32'(sts_q);
        R_MASK:  rdata_q <= 32'(mask_q);
        R_ALARM: rdata_q <= 32'(act_q);
        default: rdata_q <= pvalid ? 32'(prm_q[pidx]) : '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Millisecond tick and run holdoff
  logic [15:0] div_q, hold_q;
  logic        tick_q, run_ok;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q == 16'(TICK - 1);
      div_q  <= (div_q == 16'(TICK - 1)) ? '0 : div_q + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= '0;
    end else if (!engine_running) begin
      hold_q <= '0;
    end else if (tick_q && hold_q < prm_q[P_HOLD]) begin
      hold_q <= hold_q + 16'h0001;
    end
  end

  assign run_ok = engine_running && hold_q >= prm_q[P_HOLD];

  ////////////////////////////////////////////////////////////////
  // Persistence timers
  logic [NT-1:0] cond, fired;
  logic [15:0]   per [NT];
  logic [15:0]   tcnt_q [NT];
  logic [15:0]   neg_kw;

  assign neg_kw = 16'(-meas.kw);
  assign cond[T_VUNB] = run_ok && unb_over(meas.v1, meas.v2, meas.v3, prm_q[P_UNB]);
  assign cond[T_IUNB] = run_ok && unb_over(meas.i1, meas.i2, meas.i3, prm_q[P_UNB]);
  assign cond[T_OVL]  = meas.kw > $signed(prm_q[P_OVL]);
  assign cond[T_REV]  = meas.kw[15] && neg_kw > prm_q[P_REVL];
  assign cond[T_MCB]  = cb.mcb_fb_def && cb.mcb_open_cmd && !cb.mcb_is_open;
  assign cond[T_GCB]  = cb.gcb_fb_def && cb.gcb_close_cmd && !cb.gcb_is_closed;
  assign cond[T_SPD]  = engine_running && meas.rpm < prm_q[P_CRK];
  assign cond[T_ECU]  = ecu_check_en && !ecu_msg;

  assign per[T_VUNB] = prm_q[P_VFT];
  assign per[T_IUNB] = prm_q[P_VFT];
  assign per[T_OVL]  = prm_q[P_OVLT];
  assign per[T_REV]  = prm_q[P_REVT];
  assign per[T_MCB]  = prm_q[P_CBT];
  assign per[T_GCB]  = prm_q[P_CBT];
  assign per[T_SPD]  = prm_q[P_SPDT];
  assign per[T_ECU]  = 16'(ECU_MS);

  // Counter saturates at its period so a held fault never wraps
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NT; k++) begin
        tcnt_q[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NT; k++) begin
        if (!cond[k]) begin
          tcnt_q[k] <= '0;
        end else if (tick_q && tcnt_q[k] < per[k]) begin
          tcnt_q[k] <= tcnt_q[k] + 16'h0001;
        end
      end
    end
  end

  always_comb begin
    for (int k = 0; k < NT; k++) begin
      fired[k] = cond[k] && tcnt_q[k] >= per[k];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Inverse-time overcurrent: excess integrated per tick
  logic [15:0] imax;
  logic        oc_over;
  logic [31:0] oc_acc_q;

  assign imax = (meas.i1 > meas.i2) ? ((meas.i1 > meas.i3) ? meas.i1 : meas.i3)
                                    : ((meas.i2 > meas.i3) ? meas.i2 : meas.i3);
  assign oc_over = imax > prm_q[P_OC];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      oc_acc_q <= '0;
    end else if (!oc_over) begin
      oc_acc_q <= '0;
    end else if (tick_q && !oc_acc_q[31]) begin
      oc_acc_q <= oc_acc_q + 32'(imax - prm_q[P_OC]);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Alarm state, class, latching and protection disable
  alarm_t raw;

  always_comb begin
    raw         = '0;
    raw[A_ECU]  = fired[T_ECU];
    raw[A_VUNB] = fired[T_VUNB];
    raw[A_IUNB] = fired[T_IUNB];
    raw[A_OVC]  = oc_over && oc_acc_q >= (32'(prm_q[P_IDMT]) << IDMT_SH);
    raw[A_OVL]  = fired[T_OVL];
    raw[A_REV]  = fired[T_REV];
    raw[A_PH]   = cfg_q[CFG_PH] && phase_rev;
    raw[A_MCB]  = fired[T_MCB];
    raw[A_GCB]  = fired[T_GCB];
    raw[A_SPD]  = fired[T_SPD];
    raw[A_SVC]  = |svc_expired;
    raw[A_LOCK] = remote_lock;
    raw[A_TOPO] = cfg_q[CFG_TOPO] && run_ok && !topo_known;
  end

  // A new cause wins over a mode-command cancel
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      act_q <= '0;
    end else begin
      act_q <= raw | (act_q & latch_q & {NA{!mode_cmd}});
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sd_q   <= '0;
      ld_q   <= '0;
      warn_q <= '0;
    end else begin
      sd_q   <= dis_prot ? '0 : act_q & class_q;
      ld_q   <= dis_prot ? '0 : act_q & ~class_q;
      warn_q <= dis_prot ? act_q : '0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Interrupt: rising alarms set sticky bits, write one clears
  alarm_t act_d1_q, sts_d;

  always_comb begin
    sts_d = sts_q;
    if (wr && addr == R_STAT) begin
      sts_d = sts_q & ~wdata[NA-1:0];
    end
    sts_d = sts_d | (act_q & ~act_d1_q);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      act_d1_q <= '0;
      sts_q    <= '0;
      irq_q    <= 1'b0;
    end else begin
      act_d1_q <= act_q;
      sts_q    <= sts_d;
      irq_q    <= |(sts_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Service counter reset by two-button hold
  logic [15:0] btn_q;
  logic        both;

  assign both = btn_mute && btn_lamp;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      btn_q       <= '0;
      svc_reset_q <= 1'b0;
      done_msg_q  <= 1'b0;
    end else if (!both) begin
      btn_q       <= '0;
      svc_reset_q <= 1'b0;
      done_msg_q  <= 1'b0;
    end else begin
      if (tick_q && btn_q < 16'(SVC_MS)) begin
        btn_q <= btn_q + 16'h0001;
      end
      svc_reset_q <= btn_q == 16'(SVC_MS) && !done_msg_q;
      if (btn_q == 16'(SVC_MS)) begin
        done_msg_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  sequence s_held;
    both && btn_q == 16'(SVC_MS) && !done_msg_q;
  endsequence

  property p_svc_rst;
    @(posedge core_clk) disable iff (!nrst) s_held |=> svc_reset_q ##1 (!svc_reset_q || !both);
  endproperty
  a_svc_rst: assert property (p_svc_rst) else $error("service reset pulse wrong");

  property p_lock;
    @(posedge core_clk) disable iff (!nrst) remote_lock |=> act_q[A_LOCK];
  endproperty
  a_lock: assert property (p_lock) else $error("lock alarm missing");

  property p_svc;
    @(posedge core_clk) disable iff (!nrst) (|svc_expired) |=> act_q[A_SVC];
  endproperty
  a_svc: assert property (p_svc) else $error("service alarm missing");

  property p_dis;
    @(posedge core_clk) disable iff (!nrst) dis_prot |=> sd_q == '0 && ld_q == '0 && warn_q == $past(act_q);
  endproperty
  a_dis: assert property (p_dis) else $error("protection disable not honoured");

  property p_class;
    @(posedge core_clk) disable iff (!nrst) !dis_prot |=> sd_q == $past(act_q & class_q) && ld_q == $past(act_q & ~class_q);
  endproperty
  a_class: assert property (p_class) else $error("alarm class wrong");

  property p_latch;
    @(posedge core_clk) disable iff (!nrst) !mode_cmd |=> (~act_q & $past(act_q & latch_q)) == '0;
  endproperty
  a_latch: assert property (p_latch) else $error("latched alarm dropped");

  property p_holdoff;
    @(posedge core_clk) disable iff (!nrst) !run_ok |=> tcnt_q[T_VUNB] == '0 && tcnt_q[T_IUNB] == '0;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("unbalance checked early");

  property p_restart;
    @(posedge core_clk) disable iff (!nrst) !cond[T_OVL] |=> tcnt_q[T_OVL] == '0 && !act_q[A_OVL] || $past(act_q[A_OVL] && latch_q[A_OVL]);
  endproperty
  a_restart: assert property (p_restart) else $error("overload timer not restarted");

  property p_ecu;
    @(posedge core_clk) disable iff (!nrst) ecu_msg |=> tcnt_q[T_ECU] == '0;
  endproperty
  a_ecu: assert property (p_ecu) else $error("ECU timer not cleared");

  property p_ocp;
    @(posedge core_clk) disable iff (!nrst) !oc_over |=> oc_acc_q == '0;
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent timing kept");

  property p_phase;
    @(posedge core_clk) disable iff (!nrst) !cfg_q[CFG_PH] && !(act_q[A_PH] && latch_q[A_PH]) |=> !act_q[A_PH];
  endproperty
  a_phase: assert property (p_phase) else $error("phase alarm while disabled");

endmodule

// >>> fault_pkg.sv
// Constants, register map and carriers for the genset fault evaluator.
// Assumes one 40 MHz clock; register offsets are byte addresses.
package fault_pkg;

  localparam int CLK_NS  = 25;
  localparam int TICK_NS = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int ECU_MS  = 3000;
  localparam int SVC_S   = 5;
  localparam int SVC_MS  = SVC_S * 1000;

  localparam int NA = 13;
  localparam int NT = 8;
  localparam int NP = 12;

  // Alarm bit positions
  localparam int A_ECU  = 0;
  localparam int A_VUNB = 1;
  localparam int A_IUNB = 2;
  localparam int A_OVC  = 3;
  localparam int A_OVL  = 4;
  localparam int A_REV  = 5;
  localparam int A_PH   = 6;
  localparam int A_MCB  = 7;
  localparam int A_GCB  = 8;
  localparam int A_SPD  = 9;
  localparam int A_SVC  = 10;
  localparam int A_LOCK = 11;
  localparam int A_TOPO = 12;

  // Persistence timer slots
  localparam int T_VUNB = 0;
  localparam int T_IUNB = 1;
  localparam int T_OVL  = 2;
  localparam int T_REV  = 3;
  localparam int T_MCB  = 4;
  localparam int T_GCB  = 5;
  localparam int T_SPD  = 6;
  localparam int T_ECU  = 7;

  // Parameter slots, offset R_PRM0 + 4*slot
  localparam int P_HOLD = 0;
  localparam int P_VFT  = 1;
  localparam int P_OVLT = 2;
  localparam int P_REVT = 3;
  localparam int P_CBT  = 4;
  localparam int P_SPDT = 5;
  localparam int P_UNB  = 6;
  localparam int P_OC   = 7;
  localparam int P_OVL  = 8;
  localparam int P_REVL = 9;
  localparam int P_CRK  = 10;
  localparam int P_IDMT = 11;

  localparam logic [7:0] R_CFG   = 8'h00;
  localparam logic [7:0] R_LATCH = 8'h04;
  localparam logic [7:0] R_CLASS = 8'h08;
  localparam logic [7:0] R_STAT  = 8'h0C;
  localparam logic [7:0] R_MASK  = 8'h10;
  localparam logic [7:0] R_ALARM = 8'h14;
  localparam logic [7:0] R_PRM0  = 8'h18;

  localparam int CFG_PH   = 0;
  localparam int CFG_TOPO = 1;
  localparam int IDMT_SH  = 8;

  localparam logic [15:0] PRM_RST = 16'h7FFF;
  localparam logic [NA-1:0] CLASS_RST = 13'h0000;

  typedef logic [NA-1:0] alarm_t;

  typedef struct packed {
    logic [15:0]        v1, v2, v3;
    logic [15:0]        i1, i2, i3;
    logic signed [15:0] kw;
    logic [15:0]        rpm;
  } meas_t;

  typedef struct packed {
    logic mcb_fb_def;
    logic mcb_open_cmd;
    logic mcb_is_open;
    logic gcb_fb_def;
    logic gcb_close_cmd;
    logic gcb_is_closed;
  } cb_t;

endpackage

// >>> genset_model.sv
// Behavioural genset, breakers and front panel facing fault_eval.
// Assumes one clock; the bench steers it through plain knobs.
`timescale 1ns/1ps
module genset_model
  import fault_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic signed [15:0] kw_set,
  input  wire logic [15:0]        dev,
  input  wire logic [15:0]        rpm_set,
  input  wire logic               ecu_on,
  input  wire logic               stuck,
  input  wire logic               mcb_cmd,
  input  wire logic               gcb_cmd,
  input  wire logic               press,
  output meas_t                   meas,
  output cb_t                     cb,
  output logic                    ecu_msg,
  output logic                    btn_mute,
  output logic                    btn_lamp
);
  logic [8:0] gap_q;
  logic [3:0] fb_q;

  // Phase 1 carries the deviation on both voltage and current
  assign meas = '{16'h00E6 + dev, 16'h00E6, 16'h00E6, 16'h0064 + dev, 16'h0064, 16'h0064, kw_set, rpm_set};
  // Feedback follows the command after 8 cycles unless stuck
  assign cb = '{1'b1, mcb_cmd, mcb_cmd && fb_q[3], 1'b1, gcb_cmd, gcb_cmd && fb_q[3]};
  assign btn_mute = press;
  assign btn_lamp = press;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap_q   <= 9'h000;
      ecu_msg <= 1'b0;
    end else begin
      gap_q   <= (gap_q == 9'h18F) ? 9'h000 : gap_q + 9'h001;
      ecu_msg <= ecu_on && gap_q == 9'h18F;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fb_q <= 4'h0;
    end else if (stuck || !(mcb_cmd || gcb_cmd)) begin
      fb_q <= 4'h0;
    end else if (fb_q != 4'hF) begin
      fb_q <= fb_q + 4'h1;
    end
  end
endmodule

// >>> tb_top.sv
// Self-checking bench for fault_eval with the genset model.
// Assumes TICK shortened to 4 cycles, so one ms is 4 clocks.
`timescale 1ns/1ps
module tb_top;
  import fault_pkg::*;
  localparam int TK = 4;
  logic core_clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata_q, d;
  logic eng = 1'b0, ecu_en = 1'b0, rev = 1'b0, lock = 1'b0, topo = 1'b0;
  logic mode = 1'b0, dis = 1'b0, ecu_on = 1'b0, stuck = 1'b0, mcmd = 1'b0, gcmd = 1'b0, press = 1'b0;
  logic [2:0] svc = 3'h0;
  logic signed [15:0] kw = 16'sh0000;
  logic [15:0] dev = 16'h0000, rpm = 16'h05DC;
  meas_t meas;
  cb_t cb;
  logic ecu_msg, bm, bl, svc_rst, done_msg, irq_q;
  alarm_t sd_q, ld_q, warn_q, any_a;
  int err_total = 0, num_checks = 0;
  typedef struct packed {
    logic       lk;
    logic [2:0] sv;
    logic       rv;
    logic [1:0] cfg;
    alarm_t     exp;
  } row_t;
  row_t rows [5] = '{'{1'b1, 3'h0, 1'b0, 2'h0, 13'h0800}, '{1'b0, 3'h1, 1'b0, 2'h0, 13'h0400},
                     '{1'b0, 3'h4, 1'b0, 2'h0, 13'h0400}, '{1'b0, 3'h0, 1'b1, 2'h1, 13'h0040},
                     '{1'b0, 3'h0, 1'b1, 2'h0, 13'h0000}};
  logic [15:0] prm [NP] = '{16'h0004, 16'h0005, 16'h0005, 16'h0005, 16'h0005, 16'h0005,
                            16'h000A, 16'h7FFF, 16'h0064, 16'h0064, 16'h0258, 16'h0001};

  assign any_a = sd_q | ld_q;
  always #12.5 core_clk = ~core_clk;

  genset_model genset_model_i (.core_clk(core_clk), .nrst(nrst), .kw_set(kw), .dev(dev), .rpm_set(rpm),
    .ecu_on(ecu_on), .stuck(stuck), .mcb_cmd(mcmd), .gcb_cmd(gcmd), .press(press), .meas(meas),
    .cb(cb), .ecu_msg(ecu_msg), .btn_mute(bm), .btn_lamp(bl));
  fault_eval #(.TICK(TK)) fault_eval_i (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .meas(meas), .cb(cb), .engine_running(eng), .ecu_msg(ecu_msg),
    .ecu_check_en(ecu_en), .phase_rev(rev), .svc_expired(svc), .remote_lock(lock), .topo_known(topo),
    .mode_cmd(mode), .dis_prot(dis), .btn_mute(bm), .btn_lamp(bl), .sd_q(sd_q), .ld_q(ld_q),
    .warn_q(warn_q), .svc_reset_q(svc_rst), .done_msg_q(done_msg), .irq_q(irq_q));

  ////////////////////////////////////////////////////////////////
  task w(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // Sampled at the edge ending the data cycle
  task rd_reg(input logic [7:0] a);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
    d = rdata_q;
  endtask

  task tmd(input int b, input int p);
    w((p - 1) * TK);
    chk("alarm early", 32'h0, 32'(any_a[b]));
    w(4 * TK);
    chk("alarm late", 32'h1, 32'(any_a[b]));
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    w(6);
    chk("reset outs", 32'h0, {sd_q, ld_q, svc_rst, done_msg, irq_q});
    nrst <= 1'b1;
    rd_reg(R_PRM0 + 8'h1C);
    chk("param rst", 32'h7FFF, d);
    for (int k = 0; k < NP; k++) wr_reg(R_PRM0 + 8'(4 * k), {16'h0, prm[k]});
    wr_reg(R_CLASS, 32'h0A55);
    foreach (rows[k]) begin
      wr_reg(R_CFG, {30'h0, rows[k].cfg});
      lock <= rows[k].lk;
      svc <= rows[k].sv;
      rev <= rows[k].rv;
      w(4);
      chk("sd", 32'(rows[k].exp & 13'h0A55), 32'(sd_q));
      chk("ld", 32'(rows[k].exp & ~13'h0A55), 32'(ld_q));
      rd_reg(R_ALARM);
      chk("alarm reg", 32'(rows[k].exp), d);
      lock <= 1'b0;
      svc <= 3'h0;
      rev <= 1'b0;
    end
    wr_reg(R_CFG, 32'h2);
    eng <= 1'b1;
    dev <= 16'h003C;
    w(3 * TK);
    chk("topo", 32'h0, 32'(any_a[A_TOPO]));
    chk("vunb", 32'h0, 32'(any_a[A_VUNB]));
    w(3 * TK);
    chk("topo", 32'h1, 32'(any_a[A_TOPO]));
    chk("vunb", 32'h0, 32'(any_a[A_VUNB]));
    w(7 * TK);
    chk("vunb", 32'h1, 32'(any_a[A_VUNB]));
    chk("iunb", 32'h1, 32'(any_a[A_IUNB]));
    dev <= 16'h0000;
    topo <= 1'b1;
    kw <= 16'sh00C8;
    w(4 * TK);
    kw <= 16'sh0000;
    w(2);
    kw <= 16'sh00C8;
    w(3 * TK + 1);
    chk("ovl restart", 32'h0, 32'(any_a[A_OVL]));
    w(4 * TK);
    chk("ovl", 32'h1, 32'(any_a[A_OVL]));
    kw <= -16'sh00C8;
    tmd(A_REV, 5);
    chk("ovl gone", 32'h0, 32'(any_a[A_OVL]));
    kw <= 16'sh0000;
    wr_reg(R_PRM0 + 8'h1C, 32'h50);
    w(10 * TK);
    chk("ovc", 32'h0, 32'(any_a[A_OVC]));
    w(6 * TK);
    chk("ovc", 32'h1, 32'(any_a[A_OVC]));
    wr_reg(R_PRM0 + 8'h1C, 32'h7FFF);
    mcmd <= 1'b1;
    w(10 * TK);
    chk("mcb ok", 32'h0, 32'(any_a[A_MCB]));
    stuck <= 1'b1;
    gcmd <= 1'b1;
    tmd(A_GCB, 5);
    chk("mcb", 32'h1, 32'(any_a[A_MCB]));
    stuck <= 1'b0;
    rpm <= 16'h0000;
    tmd(A_SPD, 5);
    rpm <= 16'h05DC;
    ecu_on <= 1'b1;
    ecu_en <= 1'b1;
    w(3200 * TK);
    chk("ecu", 32'h0, 32'(any_a[A_ECU]));
    ecu_on <= 1'b0;
    w(2800 * TK);
    chk("ecu", 32'h0, 32'(any_a[A_ECU]));
    w(250 * TK);
    chk("ecu", 32'h1, 32'(any_a[A_ECU]));
    ecu_en <= 1'b0;
    wr_reg(R_LATCH, 32'h0800);
    wr_reg(R_MASK, 32'h0800);
    wr_reg(R_STAT, 32'h1FFF);
    lock <= 1'b1;
    w(5);
    chk("irq", 32'h1, 32'(irq_q));
    lock <= 1'b0;
    w(5);
    chk("latched", 32'h1, 32'(any_a[A_LOCK]));
    rd_reg(R_STAT);
    chk("stat", 32'h0800, d & 32'h0800);
    mode <= 1'b1;
    w(1);
    mode <= 1'b0;
    w(3);
    chk("unlatched", 32'h0, 32'(any_a[A_LOCK]));
    wr_reg(R_STAT, 32'h1FFF);
    w(3);
    chk("irq clr", 32'h0, 32'(irq_q));
    wr_reg(R_MASK, 32'h0);
    lock <= 1'b1;
    dis <= 1'b1;
    w(5);
    chk("irq mask", 32'h0, 32'(irq_q));
    chk("warn", 32'h1, 32'(warn_q[A_LOCK]));
    chk("no sd ld", 32'h0, 32'(any_a));
    lock <= 1'b0;
    dis <= 1'b0;
    press <= 1'b1;
    w(4990 * TK);
    chk("done early", 32'h0, 32'(done_msg));
    for (int k = 0; k < 30 * TK && svc_rst !== 1'b1; k++) w(1);
    chk("svc reset", 32'h1, 32'(svc_rst));
    w(2);
    chk("done", 32'h1, 32'(done_msg));
    press <= 1'b0;
    w(3);
    chk("done off", 32'h0, 32'(done_msg));
    wr_reg(R_ALARM, 32'h1FFF);
    rd_reg(R_ALARM);
    chk("alarm ro", 32'h0800, d);
    w(1);
    chk("rdata idle", 32'h0, rdata_q);
    rd_reg(8'hFC);
    chk("unmapped", 32'h0, d);
    give_verdict();
  end
endmodule
